// ---- design/epmc_pkg.sv ----
package epmc_pkg;
    // ==========================================
    // Widths.
    localparam int ADDR_W = 18;
    localparam int DATA_W = 8;
    // ==========================================
    // Timing at a 250 MHz reference clock.
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SETUP_US = 2;
    localparam int PULSE_US = 100;
    localparam int READ_ACCESS_NS = 250;
    localparam int SETUP_CYC = (SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PULSE_CYC = (PULSE_US * 1000000) / CLK_PERIOD_PS;
    localparam int READ_CYC = (READ_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MAX_PULSES = 25;
    localparam int CNT_W = 16;
    localparam int PCNT_W = 5;
    // ==========================================
    // Commands.
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_PROG = 2'h1;
    localparam logic [1:0] CMD_IDENT = 2'h2;
    localparam logic [1:0] CMD_VERIFY = 2'h3;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
endpackage : epmc_pkg

// ---- design/epmc_timer.sv ----
`timescale 1ns/100ps
module epmc_timer
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_load,
    input wire logic [15:0] i_count,
    output logic o_done
);
    // ==========================================
    // Down counter; o_done is high from the last counted cycle on, so a load of N spans N cycles.
    // It does not look at i_load, which keeps the sequencer free of a combinational loop.
    typedef struct packed
    {
        logic [15:0] cnt;
    } epmc_tmr_t;
    epmc_tmr_t s_q;
    epmc_tmr_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (i_load)
        begin
            s_d.cnt = i_count;
        end
        else if (s_q.cnt != 16'h0000)
        begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_done = (s_q.cnt <= 16'h0001);
endmodule : epmc_timer

// ---- design/epmc_host.sv ----
`timescale 1ns/100ps
module epmc_host
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire logic [1:0] i_req_cmd,
    input wire logic [17:0] i_req_addr,
    input wire logic [7:0] i_req_data,
    input wire logic i_req_byte_sel,
    output logic o_req_ready,
    output logic o_resp_valid,
    output logic [7:0] o_resp_data,
    output logic o_resp_fail,
    output logic o_resp_parity_ok,
    output logic [4:0] o_resp_pulses,
    output logic [17:0] o_addr,
    output logic o_chip_select_n,
    output logic o_output_gate_n,
    output logic o_program_strobe_n,
    output logic o_vpp_enable,
    output logic o_identify_high_voltage,
    output logic [7:0] o_data_out,
    output logic o_data_oe_n,
    input wire logic [7:0] i_data_in
);
    typedef enum logic [6:0]
    {
        ST_IDLE = 7'h01,
        ST_SETUP = 7'h02,
        ST_PULSE = 7'h04,
        ST_RECOV = 7'h08,
        ST_READ = 7'h10,
        ST_CHECK = 7'h20,
        ST_DONE = 7'h40
    } epmc_state_t;

    typedef struct packed
    {
        epmc_state_t st;
        logic [1:0] cmd;
        logic [17:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic [4:0] pulses;
        logic fail;
        logic ce_n;
        logic oe_n;
        logic pgm_n;
        logic vpp;
        logic vh;
        logic drive_n;
        logic [7:0] sync1;
        logic [7:0] sync2;
    } epmc_host_t;

    epmc_host_t s_q;
    epmc_host_t s_d;
    logic t_load;
    logic [15:0] t_count;
    logic t_done;

    // ==========================================
    // Wait timer for setup, pulse width and access delay.
    epmc_timer u_timer
    (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_load(t_load),
        .i_count(t_count),
        .o_done(t_done)
    );

    // ==========================================
    // Sequencer.
    always_comb
    begin
        s_d = s_q;
        t_load = 1'b0;
        t_count = 16'h0000;
        s_d.sync1 = i_data_in;
        s_d.sync2 = s_q.sync1;
        case (s_q.st)
            ST_IDLE:
            begin
                if (i_req_valid)
                begin
                    s_d.cmd = i_req_cmd;
                    s_d.wdata = i_req_data;
                    s_d.pulses = 5'h00;
                    s_d.fail = 1'b0;
                    s_d.ce_n = 1'b0;
                    t_load = 1'b1;
                    t_count = 16'(epmc_pkg::SETUP_CYC);
                    if (i_req_cmd == epmc_pkg::CMD_IDENT)
                    begin
                        // Only the byte-select line may be high while identifying.
                        s_d.addr = {17'h00000, i_req_byte_sel};
                        s_d.vh = 1'b1;
                        s_d.vpp = 1'b0;
                    end
                    else
                    begin
                        s_d.addr = i_req_addr;
                        s_d.vh = 1'b0;
                        s_d.vpp = (i_req_cmd != epmc_pkg::CMD_READ);
                    end
                    if (i_req_cmd == epmc_pkg::CMD_PROG)
                    begin
                        s_d.oe_n = 1'b1;
                        s_d.drive_n = 1'b0;
                        s_d.st = ST_SETUP;
                    end
                    else
                    begin
                        s_d.oe_n = 1'b0;
                        s_d.drive_n = 1'b1;
                        s_d.st = ST_READ;
                    end
                end
            end
            ST_SETUP:
            begin
                if (t_done)
                begin
                    s_d.pgm_n = 1'b0;
                    s_d.pulses = s_q.pulses + 5'h01;
                    t_load = 1'b1;
                    t_count = 16'(epmc_pkg::PULSE_CYC);
                    s_d.st = ST_PULSE;
                end
            end
            ST_PULSE:
            begin
                if (t_done)
                begin
                    s_d.pgm_n = 1'b1;
                    t_load = 1'b1;
                    t_count = 16'(epmc_pkg::SETUP_CYC);
                    s_d.st = ST_RECOV;
                end
            end
            ST_RECOV:
            begin
                // Data hold passed; release the bus and start the verify read.
                if (t_done)
                begin
                    s_d.drive_n = 1'b1;
                    s_d.oe_n = 1'b0;
                    t_load = 1'b1;
                    t_count = 16'(epmc_pkg::SETUP_CYC);
                    s_d.st = ST_READ;
                end
            end
            ST_READ:
            begin
                // Setup covers the access delay plus two sync stages.
                if (t_done)
                begin
                    s_d.rdata = s_q.sync2;
                    s_d.st = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                s_d.oe_n = 1'b1;
                if (s_q.cmd == epmc_pkg::CMD_PROG && s_q.rdata != s_q.wdata)
                begin
                    if (s_q.pulses == 5'(epmc_pkg::MAX_PULSES))
                    begin
                        s_d.fail = 1'b1;
                        s_d.st = ST_DONE;
                    end
                    else
                    begin
                        s_d.drive_n = 1'b0;
                        t_load = 1'b1;
                        t_count = 16'(epmc_pkg::SETUP_CYC);
                        s_d.st = ST_SETUP;
                    end
                end
                else
                begin
                    s_d.fail = (s_q.cmd == epmc_pkg::CMD_VERIFY) && (s_q.rdata != s_q.wdata);
                    s_d.st = ST_DONE;
                end
            end
            ST_DONE:
            begin
                s_d.ce_n = 1'b1;
                s_d.vpp = 1'b0;
                s_d.vh = 1'b0;
                s_d.st = ST_IDLE;
            end
            default:
            begin
                s_d.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.ce_n <= 1'b1;
            s_q.oe_n <= 1'b1;
            s_q.pgm_n <= 1'b1;
            s_q.drive_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs.
    assign o_req_ready = (s_q.st == ST_IDLE);
    assign o_resp_valid = (s_q.st == ST_DONE);
    assign o_resp_data = s_q.rdata;
    assign o_resp_fail = s_q.fail;
    assign o_resp_parity_ok = ^s_q.rdata;
    assign o_resp_pulses = s_q.pulses;
    assign o_addr = s_q.addr;
    assign o_chip_select_n = s_q.ce_n;
    assign o_output_gate_n = s_q.oe_n;
    assign o_program_strobe_n = s_q.pgm_n;
    assign o_vpp_enable = s_q.vpp;
    assign o_identify_high_voltage = s_q.vh;
    assign o_data_out = s_q.wdata;
    assign o_data_oe_n = s_q.drive_n;
endmodule : epmc_host

// ---- tb/epmc_asserts.sv ----
`timescale 1ns/100ps
module epmc_asserts
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_req_valid,
    input wire logic o_req_ready,
    input wire logic o_resp_valid,
    input wire logic [7:0] o_resp_data,
    input wire logic o_resp_parity_ok,
    input wire logic [4:0] o_resp_pulses,
    input wire logic [17:0] o_addr,
    input wire logic o_chip_select_n,
    input wire logic o_output_gate_n,
    input wire logic o_program_strobe_n,
    input wire logic o_vpp_enable,
    input wire logic o_identify_high_voltage,
    input wire logic [7:0] o_data_out,
    input wire logic o_data_oe_n
);
    // ==========
    // Strobe length and pulse count trackers.
    logic [15:0] low_q;
    logic [4:0] npulse_q;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    always_ff @(posedge i_ref_clk or posedge i_rst)
        if (i_rst)
        begin
            low_q <= 16'h0;
            npulse_q <= 5'h0;
        end
        else
        begin
            low_q <= o_program_strobe_n ? 16'h0 : low_q + 16'h1;
            npulse_q <= (i_req_valid && o_req_ready) ? 5'h0
                : npulse_q + 5'($fell(o_program_strobe_n));
        end
    property p_no_clash; !o_data_oe_n |-> o_output_gate_n; endproperty
    a_no_clash: assert property (p_no_clash) else $error("host drives with gate low");
    property p_strobe_qual;
        !o_program_strobe_n |-> o_vpp_enable && !o_chip_select_n && !o_data_oe_n;
    endproperty
    a_strobe_qual: assert property (p_strobe_qual) else $error("bad strobe mode");
    property p_width; $rose(o_program_strobe_n) |-> low_q == 16'(epmc_pkg::PULSE_CYC); endproperty
    a_width: assert property (p_width) else $error("strobe width wrong");
    property p_verify;
        $fell(o_output_gate_n) && o_vpp_enable |-> o_program_strobe_n && !o_chip_select_n;
    endproperty
    a_verify: assert property (p_verify) else $error("bad verify levels");
    property p_ident; o_identify_high_voltage |-> o_addr[17:1] == 17'h0 && !o_vpp_enable; endproperty
    a_ident: assert property (p_ident) else $error("identify address not low");
    property p_hold; !o_program_strobe_n |=> $stable(o_addr) && $stable(o_data_out); endproperty
    a_hold: assert property (p_hold) else $error("lines moved in pulse");
    property p_parity;
        o_resp_valid |-> o_resp_parity_ok == ^o_resp_data
            && (!o_identify_high_voltage || o_resp_parity_ok);
    endproperty
    a_parity: assert property (p_parity) else $error("parity flag wrong");
    property p_pulses; o_resp_valid |-> o_resp_pulses == npulse_q && o_resp_pulses <= 5'h19; endproperty
    a_pulses: assert property (p_pulses) else $error("pulse count wrong");
endmodule : epmc_asserts

// ---- tb/epmc_device_model.sv ----
`timescale 1ns/100ps
module epmc_device_model
#(
    parameter int ACC_NS = 120,
    parameter logic [17:0] WEAK_ADDR = 18'h00005,
    parameter logic [7:0] MAKER_ID = 8'h8A, // Arbitrary value, odd parity.
    parameter logic [7:0] PART_ID = 8'h07 // Arbitrary value, odd parity.
)
(
    input wire logic [17:0] i_addr,
    input wire logic i_chip_select_n,
    input wire logic i_output_gate_n,
    input wire logic i_program_strobe_n,
    input wire logic i_vpp_on,
    input wire logic i_id_hv,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq
);
    // ==========
    // Array, identifier and output drivers.
    logic [7:0] mem [0:262143];
    logic [7:0] rd;
    logic [7:0] q_dly;
    logic [7:0] q_last = 8'h00;
    logic weak_armed = 1'b1;
    wire drive = !i_chip_select_n && !i_output_gate_n;
    initial
    begin
        for (int i = 0; i < 262144; i++)
            mem[i] = 8'hFF;
        mem[18'h00005] = 8'h3C;
    end
    assign rd = i_id_hv ? (i_addr[0] ? PART_ID : MAKER_ID) : mem[i_addr];
    assign #(ACC_NS) q_dly = rd;
    always @(q_dly or drive)
        if (drive)
            q_last = q_dly;
    // A released bus shows the inverse of the last byte, never a kind value.
    assign o_dq = drive ? q_dly : ~q_last;
    always @(posedge i_program_strobe_n)
        if (i_vpp_on && !i_chip_select_n)
        begin
            // The weak cell ignores its first pulse, so the host must verify and retry.
            if (weak_armed && i_addr == WEAK_ADDR)
                weak_armed = 1'b0;
            else
                mem[i_addr] = mem[i_addr] & i_dq;
        end
endmodule : epmc_device_model

// ---- tb/eprom_mode_control_port_test.sv ----
`timescale 1ns/100ps
module eprom_mode_control_port_test;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_req_valid = 1'b0;
    logic [1:0] i_req_cmd = 2'h0;
    logic [17:0] i_req_addr = 18'h0;
    logic [7:0] i_req_data = 8'h0;
    logic i_req_byte_sel = 1'b0;
    logic o_req_ready, o_resp_valid, o_resp_fail, o_resp_parity_ok, o_data_oe_n;
    logic o_chip_select_n, o_output_gate_n, o_program_strobe_n, o_vpp_enable;
    logic o_identify_high_voltage;
    logic [7:0] o_resp_data, o_data_out, i_data_in, dq;
    logic [4:0] o_resp_pulses;
    logic [17:0] o_addr;
    int err_total = 0;
    int comparisons = 0;
    logic [1:0] r_cmd [7] = '{2'h0, 2'h0, 2'h0, 2'h3, 2'h3, 2'h2, 2'h2};
    logic [17:0] r_adr [7] = '{18'h0, 18'h3FFFF, 18'h5, 18'h5, 18'h5, 18'h0, 18'h0};
    logic [7:0] r_dat [7] = '{8'h0, 8'h0, 8'h0, 8'h3C, 8'h3D, 8'h0, 8'h0};
    logic [7:0] r_exp [7] = '{8'hFF, 8'hFF, 8'h3C, 8'h3C, 8'h3C, 8'h8A, 8'h07};
    logic r_fail [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    always #2 i_ref_clk = ~i_ref_clk;
    assign i_data_in = !o_data_oe_n ? o_data_out : dq;
    epmc_host dut (.i_ref_clk, .i_rst, .i_req_valid, .i_req_cmd, .i_req_addr, .i_req_data,
        .i_req_byte_sel, .o_req_ready, .o_resp_valid, .o_resp_data, .o_resp_fail,
        .o_resp_parity_ok, .o_resp_pulses, .o_addr, .o_chip_select_n, .o_output_gate_n,
        .o_program_strobe_n, .o_vpp_enable, .o_identify_high_voltage, .o_data_out,
        .o_data_oe_n, .i_data_in);
    epmc_device_model u_dev (.i_addr(o_addr), .i_chip_select_n(o_chip_select_n),
        .i_output_gate_n(o_output_gate_n), .i_program_strobe_n(o_program_strobe_n),
        .i_vpp_on(o_vpp_enable), .i_id_hv(o_identify_high_voltage), .i_dq(i_data_in),
        .o_dq(dq));
    // ==========
    // Shared tasks.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic req(input logic [1:0] c, input logic [17:0] a, input logic [7:0] d,
        input logic s);
        @(posedge i_ref_clk);
        i_req_valid <= 1'b1;
        i_req_cmd <= c;
        i_req_addr <= a;
        i_req_data <= d;
        i_req_byte_sel <= s;
        @(posedge i_ref_clk);
        i_req_valid <= 1'b0;
        repeat (60000)
        begin
            @(negedge i_ref_clk);
            if (o_resp_valid)
                break;
        end
        chk({7'h0, o_resp_valid}, 8'h01);
    endtask : req
    task automatic print_verdict();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    // ==========
    // Main sequence and watchdog.
    initial
    begin
        #300000;
        err_total++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            req(r_cmd[i], r_adr[i], r_dat[i], i == 6);
            chk(o_resp_data, r_exp[i]);
            chk({7'h0, o_resp_fail}, {7'h0, r_fail[i]});
            chk({7'h0, o_resp_parity_ok}, {7'h0, ^r_exp[i]});
        end
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        @(negedge i_ref_clk);
        chk({o_chip_select_n, o_output_gate_n, o_program_strobe_n, o_data_oe_n,
            o_vpp_enable, o_identify_high_voltage, 2'h0}, 8'hF0);
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        req(2'h1, 18'h5, 8'h18, 1'b0);
        chk(o_resp_data, 8'h18);
        chk({3'h0, o_resp_pulses}, 8'h02);
        chk({7'h0, o_resp_fail}, 8'h00);
        req(2'h0, 18'h5, 8'h0, 1'b0);
        chk(o_resp_data, 8'h18);
        print_verdict();
    end
endmodule : eprom_mode_control_port_test
bind epmc_host epmc_asserts u_chk (.i_ref_clk, .i_rst, .i_req_valid, .o_req_ready,
    .o_resp_valid, .o_resp_data, .o_resp_parity_ok, .o_resp_pulses, .o_addr,
    .o_chip_select_n, .o_output_gate_n, .o_program_strobe_n, .o_vpp_enable,
    .o_identify_high_voltage, .o_data_out, .o_data_oe_n);
